// ==== hw/pllcfg_bank.sv ====
// pll configuration register bank: eight bytes written byte by byte from the serial link
// Operation
// R01: host writes zero to all reserved bits
// R02: bit 12 picks crystal or reference pin
// R03: bit 38 picks oscillator or post-divider feedback
// R04: bits 13, 53 power down sections
// R05: bit 39 picks PECL or CMOS output
// R06: bits 45:44 pick loop resistor, 00 largest
// R07: bit 46 picks small or large capacitor
// R08: reference divider is bits 11:0
// R09: feedback divider is bits 37:24
// R10: bit 49 picks negative or positive sync edge
// R11: post dividers one, two: modulus code plus one
// R12: third post divider gives 1,2,4,8
// R13: bit 48 enables sync
// R14: each byte commits at its acknowledge
// R15: pump current field passes straight through
// R16: fields read back; all clear at reset
`timescale 1ns/1ps
module pllcfg_bank #(
  parameter int unsigned NUM_REGS = pllcfg_pkg::NUM_REGS
) (
  // core clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_sys_rst,
  // link clock and byte commit from the serial engine
  input  wire logic        i_link_clk,
  input  wire logic        i_ack_write,
  input  wire logic [2:0]  i_ack_ptr,
  input  wire logic [7:0]  i_ack_data,
  // read port, core domain
  input  wire logic [2:0]  i_rd_ptr,
  output logic [7:0]       o_rd_data,
  output logic             o_commit_pulse,
  // reference path
  output logic [11:0]      o_ref_divider_value,
  output logic             o_ref_source_select,
  output logic             o_power_down_first,
  // post dividers
  output logic [3:0]       o_post_divider_first,
  output logic [3:0]       o_post_divider_second,
  output logic [1:0]       o_post_divider_third,
  output logic [4:0]       o_post_modulus_first,
  output logic [4:0]       o_post_modulus_second,
  output logic [3:0]       o_post_modulus_third,
  output logic             o_post_code_illegal,
  // feedback path and output
  output logic [13:0]      o_feedback_divider_value,
  output logic             o_feedback_source_select,
  output logic             o_differential_clock_output_cmos,
  // loop tuning
  output logic [1:0]       o_pump_current_select,
  output logic [1:0]       o_loop_resistor_select,
  output logic             o_loop_capacitor_select,
  // sync and second shutdown
  output logic             o_sync_enable_bit,
  output logic             o_sync_edge_select,
  output logic             o_power_down_second
);
  // writable-bit mask of one byte
  function automatic logic [7:0] byte_mask(input logic [2:0] idx);
    unique case (idx)
      pllcfg_pkg::OFF_REF_DIVIDER_LOW:      byte_mask = pllcfg_pkg::MASK_B0;
      pllcfg_pkg::OFF_THIRD_SHUT_REFSRC_HI: byte_mask = pllcfg_pkg::MASK_B1;
      pllcfg_pkg::OFF_POST_DIVIDER_ONE_TWO: byte_mask = pllcfg_pkg::MASK_B2;
      pllcfg_pkg::OFF_FEEDBACK_DIVIDER_LOW: byte_mask = pllcfg_pkg::MASK_B3;
      pllcfg_pkg::OFF_OUTPUT_FBSRC_FB_HIGH: byte_mask = pllcfg_pkg::MASK_B4;
      pllcfg_pkg::OFF_LOOP_TUNING:          byte_mask = pllcfg_pkg::MASK_B5;
      pllcfg_pkg::OFF_SHUTDOWN_SYNC_CTRL:   byte_mask = pllcfg_pkg::MASK_B6;
      default:                              byte_mask = pllcfg_pkg::MASK_B7;
    endcase
  endfunction

  // modulus of a four-bit post divider code
  function automatic logic [4:0] post_modulus(input logic [3:0] code);
    post_modulus = {1'b0, code} + 5'h01;
  endfunction

  logic [2:0] link_ptr;
  logic [7:0] link_data;
  logic       link_tog;
  logic       commit;

  pllcfg_link u_link (
    .i_link_clk  (i_link_clk),
    .i_sys_rst   (i_sys_rst),
    .i_ack_write (i_ack_write),
    .i_ack_ptr   (i_ack_ptr),
    .i_ack_data  (i_ack_data),
    .o_ptr       (link_ptr),
    .o_data      (link_data),
    .o_tog       (link_tog)
  );

  pllcfg_sync u_sync (
    .i_core_clk (i_core_clk),
    .i_sys_rst  (i_sys_rst),
    .i_tog      (link_tog),
    .o_pulse    (commit)
  );

  typedef struct packed {
    logic [63:0] map;
    logic [7:0]  rd_data;
    logic        commit_pulse;
    logic [4:0]  mod_one;
    logic [4:0]  mod_two;
    logic [3:0]  mod_three;
    logic        illegal;
  } pllcfg_bank_s;

  pllcfg_bank_s st;
  pllcfg_bank_s next_st;
  logic [63:0]  m;

  assign m = st.map;

  always_comb begin
    next_st = st;
    // link word is stable for many core cycles by the time the pulse arrives
    if (commit) begin
      // each byte lands on its own; no wait for the end of the frame  R14
      // reserved bits masked so they read zero even if a host writes ones  R01
      next_st.map[link_ptr*pllcfg_pkg::BYTE_W +: pllcfg_pkg::BYTE_W] = link_data & byte_mask(link_ptr); // R16
    end
    next_st.commit_pulse = commit;
    next_st.rd_data      = st.map[i_rd_ptr*pllcfg_pkg::BYTE_W +: pllcfg_pkg::BYTE_W]; // R16
    next_st.mod_one   = post_modulus(m[pllcfg_pkg::POS_FIRST_LO +: pllcfg_pkg::POST_W]); // R11
    next_st.mod_two   = post_modulus(m[pllcfg_pkg::POS_SECOND_LO +: pllcfg_pkg::POST_W]); // R11
    next_st.mod_three = 4'h1 << m[pllcfg_pkg::POS_THIRD_LO +: pllcfg_pkg::THIRD_W]; // R12
    // codes above the last legal one are flagged, not corrected
    next_st.illegal = (m[pllcfg_pkg::POS_FIRST_LO +: pllcfg_pkg::POST_W] > pllcfg_pkg::POST_MAX_CODE)
                    | (m[pllcfg_pkg::POS_SECOND_LO +: pllcfg_pkg::POST_W] > pllcfg_pkg::POST_MAX_CODE); // R11
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st <= '0; // R16
    end else begin
      st <= next_st;
    end
  end

  // field outputs come straight from the map flip-flops
  assign o_rd_data      = st.rd_data;
  assign o_commit_pulse = st.commit_pulse;
  assign o_ref_divider_value      = m[pllcfg_pkg::POS_REF_DIV_LO +: pllcfg_pkg::REF_DIV_W]; // R08
  assign o_ref_source_select      = m[pllcfg_pkg::POS_REFSRC]; // R02
  assign o_power_down_first       = m[pllcfg_pkg::POS_SHUT_ONE]; // R04
  assign o_post_divider_first     = m[pllcfg_pkg::POS_FIRST_LO +: pllcfg_pkg::POST_W];
  assign o_post_divider_second    = m[pllcfg_pkg::POS_SECOND_LO +: pllcfg_pkg::POST_W];
  assign o_post_divider_third     = m[pllcfg_pkg::POS_THIRD_LO +: pllcfg_pkg::THIRD_W];
  assign o_post_modulus_first     = st.mod_one;
  assign o_post_modulus_second    = st.mod_two;
  assign o_post_modulus_third     = st.mod_three;
  assign o_post_code_illegal      = st.illegal;
  assign o_feedback_divider_value = m[pllcfg_pkg::POS_FBDIV_LO +: pllcfg_pkg::FBDIV_W]; // R09
  assign o_feedback_source_select = m[pllcfg_pkg::POS_FBSRC]; // R03
  assign o_differential_clock_output_cmos = m[pllcfg_pkg::POS_OUT_CMOS]; // R05
  assign o_pump_current_select    = m[pllcfg_pkg::POS_PUMP_LO +: 2]; // R15
  assign o_loop_resistor_select   = m[pllcfg_pkg::POS_LRES_LO +: 2]; // R06
  assign o_loop_capacitor_select  = m[pllcfg_pkg::POS_LCAP]; // R07
  assign o_sync_enable_bit        = m[pllcfg_pkg::POS_SYNC_EN]; // R13
  assign o_sync_edge_select       = m[pllcfg_pkg::POS_SYNC_EDGE]; // R10
  assign o_power_down_second      = m[pllcfg_pkg::POS_SHUT_TWO]; // R04
endmodule // pllcfg_bank

// ==== hw/pllcfg_link.sv ====
// link-clock side: captures a byte write and raises a toggle per committed byte
`timescale 1ns/1ps
module pllcfg_link (
  // link clock and reset
  input  wire logic       i_link_clk,
  input  wire logic       i_sys_rst,
  // byte acknowledged by the bus engine
  input  wire logic       i_ack_write,
  input  wire logic [2:0] i_ack_ptr,
  input  wire logic [7:0] i_ack_data,
  // held word and change toggle
  output logic [2:0]      o_ptr,
  output logic [7:0]      o_data,
  output logic            o_tog
);
  typedef struct packed {
    logic [2:0] ptr;
    logic [7:0] data;
    logic       tog;
  } pllcfg_link_s;
  pllcfg_link_s st;
  pllcfg_link_s next_st;
  always_comb begin
    next_st = st;
    // word held stable until next ack; core samples it after the toggle settles
    if (i_ack_write) begin
      next_st.ptr  = i_ack_ptr;
      next_st.data = i_ack_data;
      next_st.tog  = ~st.tog;
    end
  end
  always_ff @(posedge i_link_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign o_ptr  = st.ptr;
  assign o_data = st.data;
  assign o_tog  = st.tog;
endmodule // pllcfg_link

// ==== hw/pllcfg_pkg.sv ====
// shared constants for the pll configuration register bank
package pllcfg_pkg;
  localparam int unsigned NUM_REGS   = 8;
  localparam int unsigned BYTE_W     = 8;
  localparam int unsigned PTR_W      = 3;
  // register offsets
  localparam logic [2:0] OFF_REF_DIVIDER_LOW      = 3'h0;
  localparam logic [2:0] OFF_THIRD_SHUT_REFSRC_HI = 3'h1;
  localparam logic [2:0] OFF_POST_DIVIDER_ONE_TWO = 3'h2;
  localparam logic [2:0] OFF_FEEDBACK_DIVIDER_LOW = 3'h3;
  localparam logic [2:0] OFF_OUTPUT_FBSRC_FB_HIGH = 3'h4;
  localparam logic [2:0] OFF_LOOP_TUNING          = 3'h5;
  localparam logic [2:0] OFF_SHUTDOWN_SYNC_CTRL   = 3'h6;
  localparam logic [2:0] OFF_RESERVED_TOP_BYTE    = 3'h7;
  // writable bits per byte; reserved bits read as zero
  localparam logic [7:0] MASK_B0 = 8'hFF;
  localparam logic [7:0] MASK_B1 = 8'hFF;
  localparam logic [7:0] MASK_B2 = 8'hFF;
  localparam logic [7:0] MASK_B3 = 8'hFF;
  localparam logic [7:0] MASK_B4 = 8'hFF;
  localparam logic [7:0] MASK_B5 = 8'h73;
  localparam logic [7:0] MASK_B6 = 8'h23;
  localparam logic [7:0] MASK_B7 = 8'h00;
  localparam logic [7:0] REG_RESET = 8'h00;
  // field positions within the 64-bit map
  localparam int unsigned POS_REF_DIV_LO = 0;
  localparam int unsigned POS_REFSRC     = 12;
  localparam int unsigned POS_SHUT_ONE   = 13;
  localparam int unsigned POS_THIRD_LO   = 14;
  localparam int unsigned POS_FIRST_LO   = 16;
  localparam int unsigned POS_SECOND_LO  = 20;
  localparam int unsigned POS_FBDIV_LO   = 24;
  localparam int unsigned POS_FBSRC      = 38;
  localparam int unsigned POS_OUT_CMOS   = 39;
  localparam int unsigned POS_PUMP_LO    = 40;
  localparam int unsigned POS_LRES_LO    = 44;
  localparam int unsigned POS_LCAP       = 46;
  localparam int unsigned POS_SYNC_EN    = 48;
  localparam int unsigned POS_SYNC_EDGE  = 49;
  localparam int unsigned POS_SHUT_TWO   = 53;
  localparam int unsigned REF_DIV_W = 12;
  localparam int unsigned FBDIV_W  = 14;
  localparam int unsigned POST_W   = 4;
  localparam int unsigned THIRD_W  = 2;
  localparam logic [3:0] POST_MAX_CODE = 4'hB;
endpackage

// ==== hw/pllcfg_sync.sv ====
// three-stage synchroniser for link-domain events into the core domain
`timescale 1ns/1ps
module pllcfg_sync (
  // clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_sys_rst,
  // async toggle in
  input  wire logic i_tog,
  // one-cycle pulse on each toggle change
  output logic      o_pulse
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic pulse;
  } pllcfg_sync_s;
  pllcfg_sync_s st;
  pllcfg_sync_s next_st;
  always_comb begin
    next_st       = st;
    next_st.s1    = i_tog;
    next_st.s2    = st.s1;
    next_st.s3    = st.s2;
    // s1 only feeds s2; change counts when s2 and s3 differ
    next_st.pulse = st.s2 ^ st.s3;
  end
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign o_pulse = st.pulse;
endmodule // pllcfg_sync

// ==== verification/pllcfg_host_model.sv ====
// far-side model: bus engine handing each acknowledged byte to the bank
`timescale 1ns/1ps
module pllcfg_host_model (
  // link side
  output logic       o_link_clk = 1'b0,
  output logic       o_ack_write = 1'b0,
  output logic [2:0] o_ack_ptr = 3'h0,
  output logic [7:0] o_ack_data = 8'h00
);
  // one link period; the clock stands low between frames
  task automatic tick();
    #80 o_link_clk = 1'b1;
    #80 o_link_clk = 1'b0;
  endtask
  // one ack per byte, then an idle period so acks never come back to back
  task automatic send(input logic [2:0] p, input logic [7:0] d);
    #7;
    o_ack_write = 1'b1;
    o_ack_ptr = p;
    o_ack_data = d;
    tick();
    o_ack_write = 1'b0;
    // released lines show the inverse, not a stale copy
    o_ack_ptr = ~p;
    o_ack_data = ~d;
    tick();
  endtask
endmodule // pllcfg_host_model

// ==== verification/pllcfg_monitor.sv ====
// assertion checker for the pll configuration register bank
`timescale 1ns/1ps
module pllcfg_monitor (
  // clock and reset
  input wire logic        i_core_clk,
  input wire logic        i_sys_rst,
  // read port and decodes
  input wire logic [2:0]  i_rd_ptr,
  input wire logic [7:0]  o_rd_data,
  input wire logic        o_commit_pulse,
  input wire logic [11:0] o_ref_divider_value,
  input wire logic [3:0]  o_post_divider_first,
  input wire logic [3:0]  o_post_divider_second,
  input wire logic [1:0]  o_post_divider_third,
  input wire logic [4:0]  o_post_modulus_first,
  input wire logic [4:0]  o_post_modulus_second,
  input wire logic [3:0]  o_post_modulus_third,
  input wire logic        o_post_code_illegal
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  // decodes trail the committed field by one cycle
  sequence commit_s;
    o_commit_pulse ##1 1'b1;
  endsequence
  pulse_single_a: assert property (o_commit_pulse |=> !o_commit_pulse)
    else $error("commit pulse too long");
  map_hold_a: assert property (!o_commit_pulse |-> $stable(o_ref_divider_value) && $stable(o_post_divider_first))
    else $error("map changed without commit");
  mod_first_a: assert property (commit_s |-> o_post_modulus_first == {1'b0, o_post_divider_first} + 5'h1)
    else $error("first modulus wrong");
  mod_second_a: assert property (commit_s |-> o_post_modulus_second == {1'b0, o_post_divider_second} + 5'h1)
    else $error("second modulus wrong");
  mod_third_a: assert property (commit_s |-> o_post_modulus_third == 4'h1 << o_post_divider_third)
    else $error("third modulus wrong");
  illegal_flag_a: assert property (commit_s |-> o_post_code_illegal ==
    (o_post_divider_first > 4'hB || o_post_divider_second > 4'hB))
    else $error("illegal flag wrong");
  rsvd_read_a: assert property (i_rd_ptr == 3'h7 |=> o_rd_data == 8'h00)
    else $error("top byte not zero");
  read_back_a: assert property (i_rd_ptr == 3'h0 |=> o_rd_data == $past(o_ref_divider_value[7:0]))
    else $error("byte zero readback wrong");
endmodule // pllcfg_monitor
bind pllcfg_bank pllcfg_monitor u_monitor (.i_core_clk, .i_sys_rst, .i_rd_ptr, .o_rd_data, .o_commit_pulse,
  .o_ref_divider_value, .o_post_divider_first, .o_post_divider_second, .o_post_divider_third,
  .o_post_modulus_first, .o_post_modulus_second, .o_post_modulus_third, .o_post_code_illegal);

// ==== verification/testbench.sv ====
// self-checking bench for the pll configuration register bank
`timescale 1ns/1ps
module testbench;
  logic        i_core_clk = 1'b0;
  logic        i_sys_rst = 1'b1;
  logic [2:0]  i_rd_ptr = 3'h0;
  logic        i_link_clk, i_ack_write, o_commit_pulse, o_ref_source_select, o_power_down_first;
  logic [2:0]  i_ack_ptr;
  logic [7:0]  i_ack_data, o_rd_data;
  logic [11:0] o_ref_divider_value;
  logic [3:0]  o_post_divider_first, o_post_divider_second, o_post_modulus_third;
  logic [1:0]  o_post_divider_third, o_pump_current_select, o_loop_resistor_select;
  logic [4:0]  o_post_modulus_first, o_post_modulus_second;
  logic [13:0] o_feedback_divider_value;
  logic        o_post_code_illegal, o_feedback_source_select, o_differential_clock_output_cmos;
  logic        o_loop_capacitor_select, o_sync_enable_bit, o_sync_edge_select, o_power_down_second;
  logic [9:0]  misc;
  int          n_mismatch = 0;
  int          total_checks = 0;
  // host keeps every reserved bit zero; every writable bit set in bytes 5 and 6
  logic [7:0]  wdat [8] = '{8'h5A, 8'hF7, 8'hB0, 8'hC3, 8'hE9, 8'h73, 8'h23, 8'h00};
  logic [7:0]  rexp [8] = '{8'h5A, 8'hF7, 8'hB0, 8'hC3, 8'hE9, 8'h73, 8'h23, 8'h00};
  assign misc = {o_differential_clock_output_cmos, o_feedback_source_select, o_pump_current_select,
    o_loop_resistor_select, o_loop_capacitor_select, o_sync_enable_bit, o_sync_edge_select, o_power_down_second};
  initial forever #20 i_core_clk = ~i_core_clk;
  pllcfg_host_model host (.o_link_clk(i_link_clk), .o_ack_write(i_ack_write), .o_ack_ptr(i_ack_ptr),
    .o_ack_data(i_ack_data));
  pllcfg_bank uut (.i_core_clk, .i_sys_rst, .i_link_clk, .i_ack_write, .i_ack_ptr, .i_ack_data, .i_rd_ptr,
    .o_rd_data, .o_commit_pulse, .o_ref_divider_value, .o_ref_source_select, .o_power_down_first,
    .o_post_divider_first, .o_post_divider_second, .o_post_divider_third, .o_post_modulus_first,
    .o_post_modulus_second, .o_post_modulus_third, .o_post_code_illegal, .o_feedback_divider_value,
    .o_feedback_source_select, .o_differential_clock_output_cmos, .o_pump_current_select,
    .o_loop_resistor_select, .o_loop_capacitor_select, .o_sync_enable_bit, .o_sync_edge_select,
    .o_power_down_second);
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // reset spans a link edge as well, so both domains clear
  task automatic rst_pulse();
    i_sys_rst = 1'b1;
    fork
      host.tick();
      repeat (5) @(negedge i_core_clk);
    join
    i_sys_rst = 1'b0;
  endtask
  task automatic rd(input logic [2:0] p, input logic [7:0] exp);
    i_rd_ptr = p;
    @(negedge i_core_clk);
    chk({8'h00, o_rd_data}, {8'h00, exp});
  endtask
  task automatic wr(input logic [2:0] p, input logic [7:0] d);
    bit seen = 1'b0;
    fork
      host.send(p, d);
      for (int i = 0; i < 30 && !seen; i++) begin
        @(negedge i_core_clk);
        seen = (o_commit_pulse === 1'b1);
      end
    join
    if (!seen) begin
      n_mismatch++;
      tally_and_finish();
    end
    @(negedge i_core_clk);
  endtask
  initial begin
    rst_pulse();
    for (int b = 0; b < 8; b++) rd(3'(b), 8'h00);
    for (int b = 0; b < 8; b++) begin
      wr(3'(b), wdat[b]);
      rd(3'(b), rexp[b]);
    end
    chk(16'(o_ref_divider_value), 16'h075A);
    chk(16'({o_post_modulus_third, o_power_down_first, o_ref_source_select}), 16'h0023);
    chk(16'({o_post_modulus_second, o_post_modulus_first, o_post_code_illegal}), 16'h0302);
    chk(16'(o_feedback_divider_value), 16'h29C3);
    chk(16'(misc), 16'h03FF);
    // a multi-byte field moves one byte at a time
    wr(3'h0, 8'h00);
    chk(16'(o_ref_divider_value), 16'h0700);
    wr(3'h2, 8'hC1);
    chk(16'({o_post_code_illegal, o_post_modulus_first}), 16'h0022);
    for (int c = 0; c < 4; c++) begin
      wr(3'h1, {2'(c), 6'h00});
      chk(16'(o_post_modulus_third), 16'h0001 << c);
    end
    chk(16'({o_power_down_first, o_ref_source_select}), 16'h0000);
    wr(3'h4, 8'h00);
    wr(3'h5, 8'h12);
    wr(3'h6, 8'h02);
    chk(16'(misc), 16'h0092);
    rst_pulse();
    chk(16'(o_feedback_divider_value), 16'h0000);
    rd(3'h2, 8'h00);
    tally_and_finish();
  end
endmodule // testbench
